//--- verilog/mascn_pkg.sv
// Package: register map, fields, reset values and timing of the scan control block
// Function
// - Decode each mapped access to exactly one of eight registers; other addresses get an error response.
// - Identity register returns a read-only code distinct per variant.
// - Configuration holds scanning mode and rear-connector output enable.
// - Status reports channels settled since the last gain change.
// - Gain register holds a 1-or-100 gain choice for each of 32 channels.
// - Channel register names the single channel or the scan start channel.
// - Calibration-memory register is the access point to nonvolatile memory.
// - Control logic sequences scanning automatically; sensor selection and gain follow register writes.
// - Output multiplexer routes exactly one of 32 channels or the sensor.
// - Settled is true from reset and, after a gain change, only after the variant settling interval.
package mascn_pkg;
	localparam logic [7:0] MASCN_OFS_ID = 8'h00;
	localparam logic [7:0] MASCN_OFS_CFG = 8'h04;
	localparam logic [7:0] MASCN_OFS_STAT = 8'h08;
	localparam logic [7:0] MASCN_OFS_CAL = 8'h0C;
	localparam logic [7:0] MASCN_OFS_GAIN = 8'h10;
	localparam logic [7:0] MASCN_OFS_CHAN = 8'h14;
	localparam logic [7:0] MASCN_OFS_IRQST = 8'h18;
	localparam logic [7:0] MASCN_OFS_IRQMSK = 8'h1C;
	// Configuration fields
	localparam int MASCN_CFG_SCAN_BIT = 0;
	localparam int MASCN_CFG_REAR_BIT = 1;
	localparam int MASCN_CFG_CJ_BIT = 2;
	localparam int MASCN_CFG_CJSCAN_BIT = 3;
	// Channel register fields: channel number, and from bit 8 the current scan channel on read
	localparam int MASCN_CHAN_STEP_BIT = 8;
	// Calibration memory access fields
	localparam int MASCN_CAL_ADDR_LSB = 8;
	localparam int MASCN_CAL_WR_BIT = 16;
	// Status and interrupt bits
	localparam int MASCN_ST_SETTLED_BIT = 0;
	localparam int MASCN_ST_ADV_BIT = 1;
	localparam int MASCN_IRQ_SETTLED_BIT = 0;
	localparam int MASCN_IRQ_WRAP_BIT = 1;
	localparam logic [31:0] MASCN_RST_CFG = 32'h0000_0000;
	localparam logic [31:0] MASCN_RST_GAIN = 32'h0000_0000;
	localparam logic [4:0] MASCN_RST_CHAN = 5'h00;
	localparam logic [1:0] MASCN_RESP_OKAY = 2'b00;
	localparam logic [1:0] MASCN_RESP_SLVERR = 2'b10;
	// Identity codes: values are arbitrary
	localparam logic [7:0] MASCN_ID_SLOW = 8'hA1;
	localparam logic [7:0] MASCN_ID_MID = 8'hA2;
	localparam logic [7:0] MASCN_ID_FAST = 8'hA3;
	// Timing
	localparam longint MASCN_CLK_HZ = 200000000;
	localparam longint MASCN_SETTLE_SLOW_MS = 3000;
	localparam longint MASCN_SETTLE_MID_MS = 100;
	localparam longint MASCN_SETTLE_FAST_MS = 1;
	localparam longint MASCN_SETTLE_SLOW_CYC = MASCN_SETTLE_SLOW_MS * (MASCN_CLK_HZ / 1000);
	localparam longint MASCN_SETTLE_MID_CYC = MASCN_SETTLE_MID_MS * (MASCN_CLK_HZ / 1000);
	localparam longint MASCN_SETTLE_FAST_CYC = MASCN_SETTLE_FAST_MS * (MASCN_CLK_HZ / 1000);
	localparam longint MASCN_SCAN_MIN_NS = 3000;
	localparam longint MASCN_SCAN_MIN_CYC = (MASCN_SCAN_MIN_NS * MASCN_CLK_HZ + 999999999) / 1000000000;
	typedef enum logic [1:0] {MASCN_VAR_SLOW = 2'b00, MASCN_VAR_MID = 2'b01, MASCN_VAR_FAST = 2'b10} mascn_variant_t;
	typedef struct packed {
		logic cj_sel;
		logic [4:0] chan;
	} mascn_mux_sel_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
		logic wr;
	} mascn_cal_req_t;
endpackage

//--- verilog/mascn_top.sv
// Scan control register bank with AXI4-Lite slave, settle timer and output mux select
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module mascn_top import mascn_pkg::*; #(
	parameter mascn_variant_t VARIANT = MASCN_VAR_SLOW,
	parameter int NUM_CHAN = 32,
	parameter int CAL_DEPTH = 16,
	parameter longint SETTLE_CYC = (VARIANT == MASCN_VAR_SLOW) ? MASCN_SETTLE_SLOW_CYC :
		(VARIANT == MASCN_VAR_MID) ? MASCN_SETTLE_MID_CYC : MASCN_SETTLE_FAST_CYC
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] s_awaddr_in,
	input wire logic s_awvalid_in,
	output logic s_awready_out,
	input wire logic [31:0] s_wdata_in,
	input wire logic [3:0] s_wstrb_in,
	input wire logic s_wvalid_in,
	output logic s_wready_out,
	output logic [1:0] s_bresp_out,
	output logic s_bvalid_out,
	input wire logic s_bready_in,
	input wire logic [7:0] s_araddr_in,
	input wire logic s_arvalid_in,
	output logic s_arready_out,
	output logic [31:0] s_rdata_out,
	output logic [1:0] s_rresp_out,
	output logic s_rvalid_out,
	input wire logic s_rready_in,
	input wire logic scan_step_in,
	output mascn_mux_sel_t mux_sel_out,
	output logic [NUM_CHAN-1:0] gain_hi_out,
	output logic rear_conn_en_out,
	output logic settled_out,
	output logic irq_out
);
	// ****************************************************************
	// Reset synchroniser
	// ****************************************************************
	logic rst_s1_reg;
	logic rst_n_reg;
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg <= rst_s1_reg;
		end
	end

	// ****************************************************************
	// Step input: three flops, a rising change counts when second and third agree
	// ****************************************************************
	logic [2:0] step_sync_reg;
	logic step_level_reg;
	logic step_fire;
	always_ff @(posedge mclk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			step_sync_reg <= 3'b000;
			step_level_reg <= 1'b0;
		end else begin
			step_sync_reg <= {step_sync_reg[1:0], scan_step_in};
			if (step_sync_reg[1] == step_sync_reg[2])
				step_level_reg <= step_sync_reg[2];
		end
	end
	assign step_fire = (step_sync_reg[1] == step_sync_reg[2]) && step_sync_reg[2] && !step_level_reg;

	function automatic logic [31:0] mascn_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		end
		return r;
	endfunction

	// ****************************************************************
	// AXI4-Lite write and read channels
	// ****************************************************************
	logic aw_have_reg, aw_have_next;
	logic w_have_reg, w_have_next;
	logic [7:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic wr_do, rd_do;
	logic aw_rdy_reg, aw_rdy_next, w_rdy_reg, w_rdy_next, ar_rdy_reg, ar_rdy_next;
	logic [31:0] cfg_reg, cfg_next;
	logic [31:0] gain_reg, gain_next;
	logic [4:0] chan_reg, chan_next;
	logic [4:0] sel_reg, sel_next;
	logic [1:0] irq_st_reg, irq_st_next;
	logic [1:0] irq_msk_reg, irq_msk_next;
	logic [7:0] cal_mem [CAL_DEPTH];
	logic [7:0] cal_rd_reg, cal_rd_next;
	logic [3:0] cal_addr_reg, cal_addr_next;
	mascn_cal_req_t cal_req;
	logic [31:0] settle_cnt_reg, settle_cnt_next;
	logic settled_reg, settled_next;
	logic [15:0] step_gap_reg, step_gap_next;
	logic scan_wrap;

	assign wr_do = aw_have_reg && w_have_reg && !bvalid_reg;
	assign rd_do = s_arvalid_in && ar_rdy_reg;

	function automatic logic mascn_known(input logic [7:0] a);
		return a == MASCN_OFS_ID || a == MASCN_OFS_CFG || a == MASCN_OFS_STAT || a == MASCN_OFS_CAL ||
			a == MASCN_OFS_GAIN || a == MASCN_OFS_CHAN || a == MASCN_OFS_IRQST || a == MASCN_OFS_IRQMSK;
	endfunction

	always_comb begin
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_awvalid_in && aw_rdy_reg) begin
			aw_have_next = 1'b1;
			awaddr_next = s_awaddr_in;
		end
		if (s_wvalid_in && w_rdy_reg) begin
			w_have_next = 1'b1;
			wdata_next = s_wdata_in;
			wstrb_next = s_wstrb_in;
		end
		if (wr_do) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (mascn_known(awaddr_reg) && awaddr_reg != MASCN_OFS_ID && awaddr_reg != MASCN_OFS_STAT) ?
				MASCN_RESP_OKAY : MASCN_RESP_SLVERR;
		end else if (bvalid_reg && s_bready_in) begin
			bvalid_next = 1'b0;
		end
		// Hold off a new address or data beat until the pending response is taken
		aw_rdy_next = !aw_have_next && !bvalid_next;
		w_rdy_next = !w_have_next && !bvalid_next;
	end

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rd_do) begin
			rvalid_next = 1'b1;
			rresp_next = MASCN_RESP_OKAY;
			rdata_next = 32'h0000_0000;
			case (s_araddr_in)
				MASCN_OFS_ID: rdata_next[7:0] = (VARIANT == MASCN_VAR_SLOW) ? MASCN_ID_SLOW :
					(VARIANT == MASCN_VAR_MID) ? MASCN_ID_MID : MASCN_ID_FAST;
				MASCN_OFS_CFG: rdata_next = cfg_reg;
				MASCN_OFS_STAT: begin
					rdata_next[MASCN_ST_SETTLED_BIT] = settled_reg;
					rdata_next[MASCN_ST_ADV_BIT] = step_gap_reg != 16'h0000;
				end
				MASCN_OFS_CAL: rdata_next = {15'h0000, 1'b0, 4'h0, cal_addr_reg, cal_rd_reg};
				MASCN_OFS_GAIN: rdata_next = gain_reg;
				MASCN_OFS_CHAN: rdata_next = {19'h00000, sel_reg, 3'h0, chan_reg};
				MASCN_OFS_IRQST: rdata_next[1:0] = irq_st_reg;
				MASCN_OFS_IRQMSK: rdata_next[1:0] = irq_msk_reg;
				default: rresp_next = MASCN_RESP_SLVERR;
			endcase
		end else if (rvalid_reg && s_rready_in) begin
			rvalid_next = 1'b0;
		end
		ar_rdy_next = !rvalid_next;
	end

	// ****************************************************************
	// Registers, scan sequencer and settle timer
	// ****************************************************************
	assign cal_req = '{addr: wdata_reg[MASCN_CAL_ADDR_LSB +: 4], data: wdata_reg[7:0], wr: wdata_reg[MASCN_CAL_WR_BIT]};
	assign scan_wrap = step_fire && cfg_reg[MASCN_CFG_SCAN_BIT] && sel_reg == 5'(NUM_CHAN - 1);

	always_comb begin
		cfg_next = cfg_reg;
		gain_next = gain_reg;
		chan_next = chan_reg;
		sel_next = sel_reg;
		cal_addr_next = cal_addr_reg;
		cal_rd_next = cal_mem[cal_addr_reg];
		settle_cnt_next = settle_cnt_reg;
		settled_next = settled_reg;
		step_gap_next = (step_gap_reg != 16'h0000) ? step_gap_reg - 16'h0001 : 16'h0000;
		irq_msk_next = irq_msk_reg;
		irq_st_next = irq_st_reg;
		if (rd_do && s_araddr_in == MASCN_OFS_IRQST)
			irq_st_next = 2'b00;
		// count down, settled only once the full interval has elapsed
		if (settle_cnt_reg != 32'h0000_0000) begin
			settle_cnt_next = settle_cnt_reg - 32'h0000_0001;
			if (settle_cnt_reg == 32'h0000_0001) begin
				settled_next = 1'b1;
				irq_st_next[MASCN_IRQ_SETTLED_BIT] = 1'b1;
			end
		end
		// hardware stepping, no register write per step
		if (step_fire && cfg_reg[MASCN_CFG_SCAN_BIT]) begin
			sel_next = scan_wrap ? 5'h00 : sel_reg + 5'h01;
			step_gap_next = 16'(MASCN_SCAN_MIN_CYC);
		end
		if (scan_wrap)
			irq_st_next[MASCN_IRQ_WRAP_BIT] = 1'b1;
		if (wr_do) begin
			case (awaddr_reg)
				MASCN_OFS_CFG: cfg_next = mascn_merge(cfg_reg, wdata_reg, wstrb_reg) & 32'h0000_000F;
				MASCN_OFS_GAIN: begin
					gain_next = mascn_merge(gain_reg, wdata_reg, wstrb_reg);
					if (gain_next != gain_reg) begin
						settled_next = 1'b0;
						settle_cnt_next = 32'(SETTLE_CYC);
					end
				end
				MASCN_OFS_CHAN: begin
					chan_next = wdata_reg[4:0];
					sel_next = wdata_reg[4:0];
				end
				MASCN_OFS_CAL: cal_addr_next = cal_req.addr;
				MASCN_OFS_IRQMSK: irq_msk_next = wdata_reg[1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (wr_do && awaddr_reg == MASCN_OFS_CAL && cal_req.wr)
			cal_mem[cal_req.addr] <= cal_req.data;
	end

	always_ff @(posedge mclk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= MASCN_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= MASCN_RESP_OKAY;
			aw_rdy_reg <= 1'b1;
			w_rdy_reg <= 1'b1;
			ar_rdy_reg <= 1'b1;
			cfg_reg <= MASCN_RST_CFG;
			gain_reg <= MASCN_RST_GAIN;
			chan_reg <= MASCN_RST_CHAN;
			sel_reg <= MASCN_RST_CHAN;
			cal_addr_reg <= 4'h0;
			cal_rd_reg <= 8'h00;
			settle_cnt_reg <= 32'h0000_0000;
			settled_reg <= 1'b1;
			step_gap_reg <= 16'h0000;
			irq_st_reg <= 2'b00;
			irq_msk_reg <= 2'b00;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			aw_rdy_reg <= aw_rdy_next;
			w_rdy_reg <= w_rdy_next;
			ar_rdy_reg <= ar_rdy_next;
			cfg_reg <= cfg_next;
			gain_reg <= gain_next;
			chan_reg <= chan_next;
			sel_reg <= sel_next;
			cal_addr_reg <= cal_addr_next;
			cal_rd_reg <= cal_rd_next;
			settle_cnt_reg <= settle_cnt_next;
			settled_reg <= settled_next;
			step_gap_reg <= step_gap_next;
			irq_st_reg <= irq_st_next;
			irq_msk_reg <= irq_msk_next;
		end
	end

	// ****************************************************************
	// Outputs, all registered
	// ****************************************************************
	mascn_mux_sel_t mux_sel_reg, mux_sel_next;
	logic irq_reg;
	always_comb begin
		// sensor selection overrides the channel, so one source at a time
		mux_sel_next.cj_sel = cfg_next[MASCN_CFG_CJ_BIT];
		mux_sel_next.chan = sel_next;
	end
	always_ff @(posedge mclk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			mux_sel_reg <= '{cj_sel: 1'b0, chan: 5'h00};
			irq_reg <= 1'b0;
		end else begin
			mux_sel_reg <= mux_sel_next;
			irq_reg <= |(irq_st_next & irq_msk_next);
		end
	end

	assign s_awready_out = aw_rdy_reg;
	assign s_wready_out = w_rdy_reg;
	assign s_bvalid_out = bvalid_reg;
	assign s_bresp_out = bresp_reg;
	assign s_arready_out = ar_rdy_reg;
	assign s_rvalid_out = rvalid_reg;
	assign s_rdata_out = rdata_reg;
	assign s_rresp_out = rresp_reg;
	assign mux_sel_out = mux_sel_reg;
	assign gain_hi_out = gain_reg[NUM_CHAN-1:0];
	assign rear_conn_en_out = cfg_reg[MASCN_CFG_REAR_BIT];
	assign settled_out = settled_reg;
	assign irq_out = irq_reg;
endmodule // mascn_top
`default_nettype wire

//--- test/mascn_props.sv
// Checker: port-level properties of the scan control block
`timescale 1ns/1ps
`default_nettype none
module mascn_props import mascn_pkg::*; #(
	parameter mascn_variant_t VARIANT = MASCN_VAR_SLOW,
	parameter int SETTLE_CYC = 50
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic s_awready_out,
	input wire logic s_bvalid_out,
	input wire logic s_bready_in,
	input wire logic [1:0] s_bresp_out,
	input wire logic [7:0] s_araddr_in,
	input wire logic s_arvalid_in,
	input wire logic s_arready_out,
	input wire logic [31:0] s_rdata_out,
	input wire logic [1:0] s_rresp_out,
	input wire logic s_rvalid_out,
	input wire logic s_rready_in,
	input wire mascn_mux_sel_t mux_sel_out,
	input wire logic [31:0] gain_hi_out,
	input wire logic settled_out
);
	localparam logic [7:0] ID = (VARIANT == MASCN_VAR_SLOW) ? MASCN_ID_SLOW :
		(VARIANT == MASCN_VAR_MID) ? MASCN_ID_MID : MASCN_ID_FAST;
	logic [7:0] ar_reg, ar_next, cnt_reg, cnt_next;
	logic [31:0] gp_reg;
	// ****************
	// Helpers
	// ****************
	// Count saturates so an idle bank never trips the late check
	always_comb begin
		ar_next = (s_arvalid_in && s_arready_out) ? s_araddr_in : ar_reg;
		cnt_next = (gain_hi_out != gp_reg) ? 8'h00 : (cnt_reg == 8'hFF) ? cnt_reg : cnt_reg + 8'h01;
	end
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ar_reg <= 8'h00;
			cnt_reg <= 8'hFF;
			gp_reg <= MASCN_RST_GAIN;
		end else begin
			ar_reg <= ar_next;
			cnt_reg <= cnt_next;
			gp_reg <= gain_hi_out;
		end
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);
	a_bresp_hold: assert property (s_bvalid_out && !s_bready_in |=> s_bvalid_out && $stable(s_bresp_out))
		else $error("write response not held");
	a_rdata_hold: assert property (s_rvalid_out && !s_rready_in |=> s_rvalid_out && $stable(s_rdata_out))
		else $error("read data not held");
	a_aw_busy: assert property (s_bvalid_out |-> !s_awready_out)
		else $error("write address taken while busy");
	a_ar_busy: assert property (s_rvalid_out |-> !s_arready_out)
		else $error("read address taken while busy");
	a_id_code: assert property (s_rvalid_out && ar_reg == MASCN_OFS_ID |-> s_rdata_out[7:0] == ID)
		else $error("identity code wrong");
	a_unmapped_err: assert property (s_rvalid_out && ar_reg > MASCN_OFS_IRQMSK |->
		s_rresp_out == MASCN_RESP_SLVERR && s_rdata_out == 32'h0) else $error("unmapped read not refused");
	a_settle_drop: assert property ($changed(gain_hi_out) |-> ##[0:1] !settled_out)
		else $error("settled kept after gain change");
	a_settle_early: assert property ($rose(settled_out) |-> cnt_reg >= SETTLE_CYC - 2)
		else $error("settled too early");
	a_settle_late: assert property (cnt_reg == SETTLE_CYC + 2 |-> settled_out)
		else $error("settled too late");
	a_step_inc: assert property ($changed(mux_sel_out.chan) && !s_bvalid_out
		|-> mux_sel_out.chan == $past(mux_sel_out.chan) + 5'h01) else $error("scan step not by one");
	c_wrap: cover property ($past(mux_sel_out.chan) == 5'h1F && mux_sel_out.chan == 5'h00);
	c_settle: cover property ($rose(settled_out));
	c_slverr: cover property (s_bvalid_out && s_bresp_out == MASCN_RESP_SLVERR);
endmodule // mascn_props
bind mascn_top mascn_props #(.VARIANT(VARIANT), .SETTLE_CYC(SETTLE_CYC)) u_props (.mclk_in, .arst_n_in,
	.s_awready_out, .s_bvalid_out, .s_bready_in, .s_bresp_out, .s_araddr_in, .s_arvalid_in, .s_arready_out,
	.s_rdata_out, .s_rresp_out, .s_rvalid_out, .s_rready_in, .mux_sel_out, .gain_hi_out, .settled_out);
`default_nettype wire

//--- test/mascn_step_host.sv
// Far-side controller model: paced scan step requests
`timescale 1ns/1ps
`default_nettype none
module mascn_step_host #(
	parameter int GAP = 600
) (
	input wire logic mclk_in,
	input wire logic go_in,
	output logic scan_step_out,
	output logic busy_out
);
	int cnt = 0;
	initial begin
		scan_step_out = 1'b0;
		busy_out = 1'b0;
	end
	// Pulse is held long enough to pass the input filter
	always @(posedge mclk_in) begin
		if (!busy_out && go_in) begin
			busy_out <= 1'b1;
			cnt <= 0;
			scan_step_out <= 1'b1;
		end else if (busy_out) begin
			cnt <= cnt + 1;
			if (cnt == 7) scan_step_out <= 1'b0;
			if (cnt == GAP) busy_out <= 1'b0;
		end
	end
endmodule // mascn_step_host
`default_nettype wire

//--- test/tb_top.sv
// Testbench: register accesses, settling, interrupts and scanning
`timescale 1ns/1ps
`default_nettype none
module tb_top import mascn_pkg::*;;
	logic mclk_in = 1'b0, arst_n_in = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
	logic go = 1'b0, aw_r, w_r, b_v, ar_r, r_v, rear, settled, irq, step, busy;
	logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
	logic [31:0] w_d = 32'h0, rdat, r_data, gain;
	logic [1:0] rsp, b_resp, r_resp;
	mascn_mux_sel_t sel;
	int bad_count = 0, checks = 0, cyc = 0, t0, i;
	always #2.5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) cyc <= cyc + 1;
	mascn_top #(.VARIANT(MASCN_VAR_MID), .SETTLE_CYC(50)) DUT (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.s_awaddr_in(aw_a), .s_awvalid_in(aw_v), .s_awready_out(aw_r), .s_wdata_in(w_d), .s_wstrb_in(4'hF),
		.s_wvalid_in(w_v), .s_wready_out(w_r), .s_bresp_out(b_resp), .s_bvalid_out(b_v), .s_bready_in(b_rdy),
		.s_araddr_in(ar_a), .s_arvalid_in(ar_v), .s_arready_out(ar_r), .s_rdata_out(r_data),
		.s_rresp_out(r_resp), .s_rvalid_out(r_v), .s_rready_in(r_rdy), .scan_step_in(step),
		.mux_sel_out(sel), .gain_hi_out(gain), .rear_conn_en_out(rear), .settled_out(settled), .irq_out(irq));
	mascn_step_host #(.GAP(600)) u_host (.mclk_in(mclk_in), .go_in(go), .scan_step_out(step), .busy_out(busy));
	// ****************
	// Tasks
	// ****************
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		aw_a <= a; w_d <= d; aw_v <= 1'b1; w_v <= 1'b1; b_rdy <= 1'b1;
		do begin
			@(posedge mclk_in);
			if (aw_r) aw_v <= 1'b0;
			if (w_r) w_v <= 1'b0;
		end while (!b_v);
		rsp = b_resp;
		b_rdy <= 1'b0;
		// Two more edges before the next access; the mux select already updates on the same edge as the write
		repeat (2) @(posedge mclk_in);
	endtask
	task rd(input logic [7:0] a);
		ar_a <= a; ar_v <= 1'b1; r_rdy <= 1'b1;
		do begin
			@(posedge mclk_in);
			if (ar_r) ar_v <= 1'b0;
		end while (!r_v);
		rdat = r_data; rsp = r_resp;
		r_rdy <= 1'b0;
		@(posedge mclk_in);
	endtask
	task scan_step;
		go <= 1'b1;
		@(posedge mclk_in);
		go <= 1'b0;
		@(posedge mclk_in);
		while (busy) @(posedge mclk_in);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk_in);
		bad_count++;
		close_out;
	end
	// ****************
	// Sequence
	// ****************
	initial begin
		repeat (3) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		rd(MASCN_OFS_ID); chk("id", MASCN_ID_MID, rdat[7:0]);
		wr(MASCN_OFS_ID, 32'h55); chk("id wr", MASCN_RESP_SLVERR, rsp);
		rd(MASCN_OFS_ID); chk("id kept", MASCN_ID_MID, rdat[7:0]);
		rd(8'h20); chk("unmapped rd", MASCN_RESP_SLVERR, rsp);
		wr(8'h20, 32'hFFFF_FFFF); chk("unmapped wr", MASCN_RESP_SLVERR, rsp);
		rd(MASCN_OFS_GAIN); chk("gain rst", MASCN_RST_GAIN, rdat);
		wr(MASCN_OFS_CFG, 32'h2); chk("rear", 1'b1, rear);
		rd(MASCN_OFS_CFG); chk("cfg", 32'h2, rdat);
		wr(MASCN_OFS_CFG, 32'h4); chk("cj sel", 1'b1, sel.cj_sel);
		chk("rear off", 1'b0, rear);
		wr(MASCN_OFS_CFG, 32'h0); chk("cj off", 1'b0, sel.cj_sel);
		$display("test decode done");
		wr(MASCN_OFS_IRQMSK, 32'h0);
		t0 = cyc;
		wr(MASCN_OFS_GAIN, 32'h8000_0001); chk("gain", 32'h8000_0001, gain);
		chk("unsettled", 1'b0, settled);
		rd(MASCN_OFS_STAT); chk("stat low", 1'b0, rdat[0]);
		while (settled !== 1'b1 && cyc - t0 < 200) @(posedge mclk_in);
		chk("settle time", 1'b1, cyc - t0 >= 50 && cyc - t0 <= 60);
		rd(MASCN_OFS_STAT); chk("stat high", 1'b1, rdat[0]);
		chk("irq masked", 1'b0, irq);
		wr(MASCN_OFS_IRQMSK, 32'h1); chk("irq", 1'b1, irq);
		rd(MASCN_OFS_IRQST); chk("irq st", 2'b01, rdat[1:0]);
		@(posedge mclk_in); chk("irq clr", 1'b0, irq);
		wr(MASCN_OFS_GAIN, 32'h8000_0001); chk("same gain", 1'b1, settled);
		$display("test settle done");
		wr(MASCN_OFS_CHAN, 32'd30); chk("start", 5'd30, sel.chan);
		wr(MASCN_OFS_CFG, 32'h1);
		for (i = 31; i < 34; i++) begin
			scan_step; chk("scan", i % 32, sel.chan);
		end
		rd(MASCN_OFS_CHAN); chk("chan rd", 5'd1, rdat[12:8]);
		rd(MASCN_OFS_IRQST); chk("wrap st", 2'b10, rdat[1:0]);
		wr(MASCN_OFS_CFG, 32'h0);
		scan_step; chk("single", 5'd1, sel.chan);
		$display("test scan done");
		wr(MASCN_OFS_CAL, 32'h0001_05A5);
		wr(MASCN_OFS_CAL, 32'h0001_06C3);
		wr(MASCN_OFS_CAL, 32'h0000_0500);
		rd(MASCN_OFS_CAL); chk("cal", 12'h5A5, rdat[11:0]);
		$display("test cal done");
		close_out;
	end
endmodule // tb_top
`default_nettype wire
